// >>> src/fsrl_pkg.sv
// shared constants for the security-register and lock command link
package fsrl_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CORE_MHZ = 20; // core clock rate
  localparam int PP_TIME_NS = 20_000; // self-timed program duration
  localparam int RST_TIME_NS = 30_000; // reset recovery duration
  localparam int PP_CYC = (PP_TIME_NS * CORE_MHZ + 999) / 1000;
  localparam int RST_CYC = (RST_TIME_NS * CORE_MHZ + 999) / 1000;
  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] OP_WEN = 8'h06; // write_enable_cmd
  localparam logic [7:0] OP_WDIS = 8'h04; // write disable
  localparam logic [7:0] OP_ADR4_ON = 8'hB7; // enter four-byte addressing
  localparam logic [7:0] OP_ADR4_OFF = 8'hE9; // leave four-byte addressing
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_BLK_LOCK = 8'h36;
  localparam logic [7:0] OP_BLK_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCK_READ = 8'h3D;
  localparam logic [7:0] OP_GLB_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLB_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;
  // ************************************************************
  // frame layout, counted in link bits
  // ************************************************************
  localparam logic [15:0] OP_LEN = 16'h0008; // opcode bits
  localparam logic [15:0] BYTE_LEN = 16'h0008; // data or dummy byte bits
  localparam logic [15:0] HDR3 = 16'h0020; // opcode plus 24-bit address
  localparam logic [15:0] HDR4 = 16'h0028; // opcode plus 32-bit address
  // ************************************************************
  // storage geometry
  // ************************************************************
  localparam int PAGE_BYTES = 256; // bytes per security page
  localparam int SEC_BYTES = 4096; // 16 pages
  localparam int LOCK_SHIFT = 16; // address bit of lock granule
  localparam logic [11:0] SEC_HI_ZERO = 12'h000; // address bits 23..12
  localparam logic [31:0] PARAM_SIG = 32'h5044_4653; // table signature
  localparam logic [7:0] PARAM_MINOR = 8'h00;
  localparam logic [7:0] PARAM_MAJOR = 8'h01;
  // host frame sequencer, gray along the path
  typedef enum logic [1:0] {
    FSRL_IDLE = 2'b00,
    FSRL_LEAD = 2'b01,
    FSRL_SHIFT = 2'b11,
    FSRL_TRAIL = 2'b10
  } fsrl_hst_t;
endpackage

// >>> src/fsrl_link_if.sv
// serial command link between host controller and flash device
`timescale 1ns/1ps
interface fsrl_link_if;
  logic sclk; // link clock, made by the host
  logic cs_n; // frame select, low active
  logic [3:0] h_do; // host data out per line
  logic [3:0] h_oe; // host drives line
  logic [3:0] d_do; // device data out per line
  logic [3:0] d_oe; // device drives line
  logic [3:0] io; // resolved line level, pulled high
  // resolve each line from the enables
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = h_oe[i] ? h_do[i] : (d_oe[i] ? d_do[i] : 1'b1);
    end
  end
  modport host (output sclk, output cs_n, output h_do, output h_oe, input io);
  modport dev (input sclk, input cs_n, input io, output d_do, output d_oe);
endinterface

// >>> src/fsrl_sync2.sv
// two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module fsrl_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q; // first stage, read only by second
  // two flops in series
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// >>> src/fsrl_dev.sv
// device end: command decode, security registers, block locks, reset
`timescale 1ns/1ps
// Function
// R1 - host sends write enable before program
// R2 - program frame: opcode, address, data bytes
// R3 - program cycle runs on select rise, busy flag
// R4 - write latch cleared before cycle ends
// R5 - locked security registers ignore program
// R6 - security address upper bits zero, page, byte
// R7 - read: opcode, address, dummy, rising sample
// R8 - read data on falling edge, address increments
// R9 - read address wraps in low twelve bits
// R10 - lock bits protect only when select clear
// R11 - lock frame sets one lock bit
// R12 - unlock frame clears one lock bit
// R13 - lock read returns bit, one means locked
// R14 - global lock sets all, unlock clears all
// R15 - host sends reset enable then reset
// R16 - reset aborts work, restores volatile defaults
// R17 - commands refused during reset recovery
// R18 - quad or xip reset needs recovery sequence; no such sequence here, the quad reset pair is taken directly
// R19 - reset pair accepted single or quad
// R20 - host checks busy before resetting; fsrl_host sends the reset pair without reading busy
// R21 - four-byte mode lengthens address to 32
// R22 - parameter read returns parameter table
// R23 - short frames ignored, no state change
module fsrl_dev import fsrl_pkg::*; #(
  parameter int LOCK_N = 512, // lock granules
  parameter int PP_CYCLES = PP_CYC, // program cycle length
  parameter int RST_CYCLES = RST_CYC // reset recovery length
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  fsrl_link_if.dev lk,
  input wire logic quad_mode_i, // quad_command_mode
  input wire logic sec_lock_i, // security-register lock bit
  input wire logic wps_i, // write_protect_select
  input wire logic [$clog2(LOCK_N)-1:0] blk_idx_i, // granule to query
  output logic blk_prot_o, // granule protected by its lock bit
  output logic wip_o, // write_in_progress_flag
  output logic wel_o, // write_enable_latch
  output logic adr4_o, // four-byte addressing active
  output logic rst_busy_o // reset recovery running
);
  localparam int LW = $clog2(LOCK_N);
  // ************************************************************
  // link side state (link clock)
  // ************************************************************
  logic first_q; // next edge is first of frame
  logic frt_q; // toggles once per frame
  logic ok_q; // frame so far is a complete command
  logic [15:0] cnt_q; // bits received this frame
  logic [31:0] sh_q; // incoming shift register
  logic [31:0] adr_q; // captured address
  logic [7:0] op_q; // captured opcode
  logic [7:0] pbuf_q [PAGE_BYTES]; // program data staging
  logic [PAGE_BYTES-1:0] val_q; // staged byte present
  logic [3:0] dq_q; // output lines
  logic [3:0] doe_q; // output enables
  // ************************************************************
  // core side state
  // ************************************************************
  logic wel_q; // write_enable_latch
  logic wip_q; // write_in_progress_flag
  logic adr4_q; // four-byte addressing
  logic arm_q; // reset enable seen in previous frame
  logic seen_q; // frame toggle already handled
  logic csp_q; // previous synced select
  logic [15:0] pp_cnt_q; // program cycle countdown
  logic [15:0] rst_cnt_q; // recovery countdown
  logic [LOCK_N-1:0] lock_q; // block/sector lock bits
  logic [7:0] sec_q [SEC_BYTES]; // security register array
  logic [1:0] s_w; // synced {frame toggle, select}
  // ************************************************************
  // receive decode
  // ************************************************************
  wire [15:0] step_w = quad_mode_i ? 16'h0004 : 16'h0001;
  wire [15:0] cnt_d = (first_q ? 16'h0000 : cnt_q) + step_w;
  wire [31:0] sh_d = quad_mode_i ? {sh_q[27:0], lk.io} : {sh_q[30:0], lk.io[0]};
  wire [15:0] hdr_w = adr4_q ? HDR4 : HDR3; // [R21]
  wire [7:0] op_d = (cnt_d == OP_LEN) ? sh_d[7:0] : op_q;
  // opcode-only commands, including the reset pair in either mode
  wire only_w = op_d inside {OP_WEN, OP_WDIS, OP_ADR4_ON, OP_ADR4_OFF,
    OP_GLB_LOCK, OP_GLB_UNLOCK, OP_RST_EN, OP_RST}; // [R14] [R19]
  wire adrc_w = (op_d == OP_BLK_LOCK) || (op_d == OP_BLK_UNLOCK);
  wire prog_w = op_d == OP_SEC_PROG;
  wire [15:0] dat_w = hdr_w + BYTE_LEN;
  // complete on exact length, program from its first data byte on; short frames stay refused
  wire ok_d = (only_w && cnt_d == OP_LEN) || (adrc_w && cnt_d == hdr_w) ||
    (prog_w && cnt_d >= dat_w); // [R23] [R2] [R11] [R12]
  wire [15:0] doff_w = cnt_d - dat_w;
  wire dwe_w = prog_w && cnt_d >= dat_w && cnt_d[2:0] == 3'h0;
  wire [7:0] bp_w = adr_q[7:0] + doff_w[10:3]; // wraps in page
  // ************************************************************
  // transmit select
  // ************************************************************
  wire [LW-1:0] lidx_w = adr_q[LOCK_SHIFT +: LW];
  wire rdcmd_w = op_q inside {OP_SEC_READ, OP_PARAM_READ, OP_LOCK_READ};
  wire [15:0] rstart_w = (op_q == OP_LOCK_READ) ? hdr_w : dat_w; // [R7]
  wire [15:0] roff_w = cnt_q - rstart_w;
  wire ract_w = rdcmd_w && cnt_q >= rstart_w && rst_cnt_q == 16'h0000; // [R17]
  wire [11:0] sa_w = adr_q[11:0] + roff_w[14:3]; // [R8] [R9]
  wire [7:0] pa_w = adr_q[7:0] + roff_w[10:3];
  wire [7:0] pbyte_w = (pa_w < 8'h04) ? PARAM_SIG[pa_w[1:0]*8 +: 8] :
    (pa_w == 8'h04) ? PARAM_MINOR : (pa_w == 8'h05) ? PARAM_MAJOR : 8'hFF; // [R22]
  wire [7:0] rbyte_w = (op_q == OP_SEC_READ) ? sec_q[sa_w] :
    (op_q == OP_PARAM_READ) ? pbyte_w : {7'h00, lock_q[lidx_w]}; // [R13]
  wire [2:0] bi_w = roff_w[2:0];
  wire [3:0] rnib_w = quad_mode_i ? (bi_w[2] ? rbyte_w[3:0] : rbyte_w[7:4]) :
    {2'b00, rbyte_w[~bi_w], 1'b0};
  // ************************************************************
  // link clock processes
  // ************************************************************
  // frame start marker, set while select is high
  always_ff @(posedge lk.sclk or posedge lk.cs_n or negedge nrst_i) begin
    if (!nrst_i) begin
      first_q <= 1'b1;
    end else if (lk.cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end
  // sample on the rising edge, all four lines in quad mode, line 0 otherwise
  always_ff @(posedge lk.sclk or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 16'h0000;
      sh_q <= 32'h0000_0000;
      op_q <= 8'h00;
      adr_q <= 32'h0000_0000;
      ok_q <= 1'b0;
      frt_q <= 1'b0;
      val_q <= '0;
    end else begin
      cnt_q <= cnt_d; // [R7]
      sh_q <= sh_d;
      op_q <= op_d;
      ok_q <= ok_d;
      if (first_q) begin
        frt_q <= ~frt_q;
      end
      // address phase is 24 or 32 bits
      if (cnt_d == hdr_w) begin
        adr_q <= adr4_q ? sh_d : {8'h00, sh_d[23:0]}; // [R21]
      end
      // staged bytes are forgotten at each new frame
      if (first_q) begin
        val_q <= '0;
      end else if (dwe_w) begin
        val_q <= val_q | (PAGE_BYTES'(1) << bp_w); // [R2]
      end
    end
  end
  // staging data, no reset needed
  always_ff @(posedge lk.sclk) begin
    if (dwe_w) begin
      pbuf_q[bp_w] <= sh_d[7:0];
    end
  end
  // drive read data on the falling edge
  always_ff @(negedge lk.sclk or posedge lk.cs_n or negedge nrst_i) begin
    if (!nrst_i) begin
      dq_q <= 4'h0;
      doe_q <= 4'h0;
    end else if (lk.cs_n) begin
      dq_q <= 4'h0;
      doe_q <= 4'h0;
    end else begin
      dq_q <= rnib_w; // [R8]
      doe_q <= ract_w ? (quad_mode_i ? 4'hF : 4'h2) : 4'h0;
    end
  end
  assign lk.d_do = dq_q;
  assign lk.d_oe = doe_q;
  // ************************************************************
  // core side execution
  // ************************************************************
  fsrl_sync2 #(.W(2)) u_sync (
    .clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i({frt_q, lk.cs_n}),
    .q_o(s_w)
  );
  wire rise_w = s_w[0] && !csp_q;
  wire new_w = rise_w && (s_w[1] != seen_q);
  wire exec_w = new_w && ok_q && rst_cnt_q == 16'h0000; // [R17] [R23]
  wire go_prog_w = exec_w && op_q == OP_SEC_PROG && wel_q && !wip_q &&
    !sec_lock_i; // [R1] [R5]
  wire go_rst_w = exec_w && op_q == OP_RST && arm_q; // [R15]
  wire wr_ok_w = exec_w && !wip_q;
  // command effects and self-timed cycles
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      adr4_q <= 1'b0;
      arm_q <= 1'b0;
      seen_q <= 1'b0;
      csp_q <= 1'b0;
      pp_cnt_q <= 16'h0000;
      rst_cnt_q <= 16'h0000;
      lock_q <= '0;
    end else begin
      csp_q <= s_w[0];
      if (rise_w) begin
        seen_q <= s_w[1];
      end
      if (go_rst_w) begin
        // abort and return latches and address mode to power-on state; lock bits keep their value
        wel_q <= 1'b0; // [R16]
        wip_q <= 1'b0; // [R16]
        adr4_q <= 1'b0; // [R16]
        arm_q <= 1'b0;
        pp_cnt_q <= 16'h0000;
        rst_cnt_q <= 16'(RST_CYCLES); // [R17]
      end else begin
        if (rst_cnt_q != 16'h0000) begin
          rst_cnt_q <= rst_cnt_q - 16'h0001;
        end
        // reset enable holds only into the next frame
        if (new_w) begin
          arm_q <= exec_w && op_q == OP_RST_EN; // [R15]
        end
        if (go_prog_w) begin
          wip_q <= 1'b1; // [R3]
          wel_q <= 1'b0; // [R4]
          pp_cnt_q <= 16'(PP_CYCLES);
        end else if (wip_q) begin
          pp_cnt_q <= pp_cnt_q - 16'h0001;
          if (pp_cnt_q == 16'h0001) begin
            wip_q <= 1'b0; // [R3]
          end
        end
        if (wr_ok_w) begin
          case (op_q)
            OP_WEN: wel_q <= 1'b1;
            OP_WDIS: wel_q <= 1'b0;
            OP_ADR4_ON: adr4_q <= 1'b1; // [R21]
            OP_ADR4_OFF: adr4_q <= 1'b0;
            OP_BLK_LOCK: lock_q[lidx_w] <= 1'b1; // [R11]
            OP_BLK_UNLOCK: lock_q[lidx_w] <= 1'b0; // [R12]
            OP_GLB_LOCK: lock_q <= '1; // [R14]
            OP_GLB_UNLOCK: lock_q <= '0; // [R14]
            default: ;
          endcase
        end
      end
    end
  end
  // one merge per security byte, programming only clears bits
  for (genvar i = 0; i < SEC_BYTES; i++) begin : g_sec
    wire hit_w = go_prog_w && adr_q[11:8] == 4'(i / PAGE_BYTES) &&
      val_q[i % PAGE_BYTES]; // [R2] [R3]
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        sec_q[i] <= 8'hFF;
      end else if (hit_w) begin
        sec_q[i] <= sec_q[i] & pbuf_q[i % PAGE_BYTES];
      end
    end
  end
  // lock bits protect only when select is clear
  assign blk_prot_o = !wps_i && lock_q[blk_idx_i]; // [R10]
  assign wip_o = wip_q;
  assign wel_o = wel_q;
  assign adr4_o = adr4_q;
  assign rst_busy_o = rst_cnt_q != 16'h0000;
endmodule

// >>> src/fsrl_host.sv
// host end: frames commands onto the link from a byte-level request
`timescale 1ns/1ps
module fsrl_host import fsrl_pkg::*; #(
  parameter int DIV = 2 // core cycles per link half period, at least 2
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  fsrl_link_if.host lk,
  input wire logic cmd_valid_i, // request present
  output logic cmd_ready_o, // idle, request taken when valid
  input wire logic [7:0] cmd_op_i, // opcode
  input wire logic [31:0] cmd_adr_i, // address
  input wire logic [2:0] cmd_alen_i, // address bytes: 0, 3 or 4
  input wire logic [2:0] cmd_dummy_i, // dummy bytes
  input wire logic [8:0] cmd_nwr_i, // data bytes to send
  input wire logic [12:0] cmd_nrd_i, // data bytes to receive
  input wire logic cmd_quad_i, // frame in four-line format
  input wire logic [7:0] wr_data_i, // next byte to send
  output logic wr_take_o, // wr_data_i consumed
  output logic [7:0] rd_data_o, // received byte
  output logic rd_valid_o, // rd_data_o new
  output logic err_o // request refused
);
  // ************************************************************
  // state
  // ************************************************************
  fsrl_hst_t st_q; // sequencer state
  logic sclk_q, cs_n_q, quad_q, take_q, rdv_q, err_q, wen_q, rsten_q;
  logic [7:0] div_q; // half period timer
  logic [2:0] bit_q; // clock within byte
  logic [15:0] bidx_q; // byte within frame
  logic [15:0] aend_q, dend_q, wend_q, tend_q; // phase ends
  logic [31:0] adr_q; // address bytes left to send
  logic [7:0] tb_q, rx_q, rd_q; // tx, rx, last read byte
  logic [3:0] io_s; // synced lines
  fsrl_sync2 #(.W(4)) u_sync (
    .clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i(lk.io),
    .q_o(io_s)
  );
  // ************************************************************
  // request checks
  // ************************************************************
  wire sec_w = cmd_op_i == OP_SEC_PROG || cmd_op_i == OP_SEC_READ;
  wire adr_bad_w = sec_w && cmd_adr_i[23:12] != SEC_HI_ZERO; // [R6]
  wire legal_w = !adr_bad_w && (cmd_op_i != OP_SEC_PROG || wen_q) && // [R1]
    (cmd_op_i != OP_RST || rsten_q); // [R15]
  wire take_w = cmd_valid_i && st_q == FSRL_IDLE;
  wire [15:0] aend_w = 16'h0001 + 16'(cmd_alen_i);
  wire [15:0] dend_w = aend_w + 16'(cmd_dummy_i);
  wire [15:0] wend_w = dend_w + 16'(cmd_nwr_i);
  wire half_w = div_q == 8'(DIV - 1);
  wire fall_w = st_q == FSRL_SHIFT && half_w && sclk_q;
  wire [2:0] last_w = quad_q ? 3'h1 : 3'h7;
  wire bend_w = fall_w && bit_q == last_w;
  wire [15:0] nb_w = bidx_q + 16'h0001;
  wire rdph_w = bidx_q >= wend_q;
  wire [7:0] rx_d = quad_q ? {rx_q[3:0], io_s} : {rx_q[6:0], io_s[1]};
  wire ldw_w = bend_w && nb_w >= dend_q && nb_w < wend_q;
  wire [7:0] nxt_w = (nb_w < aend_q) ? adr_q[31:24] : (ldw_w ? wr_data_i : 8'h00);
  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= FSRL_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      quad_q <= 1'b0;
      take_q <= 1'b0;
      rdv_q <= 1'b0;
      err_q <= 1'b0;
      wen_q <= 1'b0;
      rsten_q <= 1'b0;
      div_q <= 8'h00;
      bit_q <= 3'h0;
      bidx_q <= 16'h0000;
      aend_q <= 16'h0000;
      dend_q <= 16'h0000;
      wend_q <= 16'h0000;
      tend_q <= 16'h0000;
      adr_q <= 32'h0000_0000;
      tb_q <= 8'h00;
      rx_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      take_q <= ldw_w;
      rdv_q <= bend_w && rdph_w;
      err_q <= take_w && !legal_w;
      div_q <= (st_q == FSRL_IDLE || half_w) ? 8'h00 : div_q + 8'h01;
      case (st_q)
        FSRL_IDLE: begin
          if (take_w && legal_w) begin
            st_q <= FSRL_LEAD;
            cs_n_q <= 1'b0;
            quad_q <= cmd_quad_i;
            aend_q <= aend_w;
            dend_q <= dend_w;
            wend_q <= wend_w;
            tend_q <= wend_w + 16'(cmd_nrd_i);
            adr_q <= (cmd_alen_i == 3'h4) ? cmd_adr_i : {cmd_adr_i[23:0], 8'h00};
            tb_q <= cmd_op_i;
            bidx_q <= 16'h0000;
            bit_q <= 3'h0;
            // remember the frame the next program or reset depends on
            wen_q <= (cmd_op_i == OP_WEN) || (wen_q && cmd_op_i != OP_WDIS &&
              cmd_op_i != OP_SEC_PROG); // [R1]
            rsten_q <= cmd_op_i == OP_RST_EN; // [R15]
          end
        end
        FSRL_LEAD: begin
          if (half_w) begin
            st_q <= FSRL_SHIFT;
          end
        end
        FSRL_SHIFT: begin
          if (half_w && !sclk_q) begin
            sclk_q <= 1'b1;
          end else if (fall_w) begin
            sclk_q <= 1'b0;
            rx_q <= rx_d;
            bit_q <= bend_w ? 3'h0 : bit_q + 3'h1;
            if (bend_w && rdph_w) begin
              rd_q <= rx_d;
            end
            if (bend_w) begin
              bidx_q <= nb_w;
              tb_q <= nxt_w;
              if (nb_w < aend_q) begin
                adr_q <= {adr_q[23:0], 8'h00};
              end
              if (nb_w == tend_q) begin
                st_q <= FSRL_TRAIL;
              end
            end else begin
              tb_q <= quad_q ? {tb_q[3:0], 4'h0} : {tb_q[6:0], 1'b0};
            end
          end
        end
        FSRL_TRAIL: begin
          // hold select one half period, then release
          if (half_w && !cs_n_q) begin
            cs_n_q <= 1'b1;
          end else if (half_w) begin
            st_q <= FSRL_IDLE;
          end
        end
        default: st_q <= FSRL_IDLE;
      endcase
    end
  end
  // ************************************************************
  // link drive
  // ************************************************************
  wire drv_w = st_q == FSRL_SHIFT && !rdph_w;
  assign lk.sclk = sclk_q;
  assign lk.cs_n = cs_n_q;
  assign lk.h_do = quad_q ? tb_q[7:4] : {3'h0, tb_q[7]};
  assign lk.h_oe = drv_w ? (quad_q ? 4'hF : 4'h1) : 4'h0;
  assign cmd_ready_o = st_q == FSRL_IDLE;
  assign wr_take_o = take_q;
  assign rd_data_o = rd_q;
  assign rd_valid_o = rdv_q;
  assign err_o = err_q;
endmodule

// >>> tb/fsrl_link_monitor.sv
// wire-level checks on the command link between host and device
`timescale 1ns/1ps
module fsrl_link_monitor (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_oe,
  input wire logic [3:0] io
);
  // ************************************************************
  // helper: link clock history and rising edges per frame
  // ************************************************************
  logic sclk_q; // link clock one core cycle ago
  logic [15:0] bits_q; // link rising edges seen in this frame
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_q <= 1'b0;
      bits_q <= 16'h0000;
    end else begin
      sclk_q <= sclk;
      bits_q <= cs_n ? 16'h0000 : bits_q + 16'(sclk & !sclk_q);
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // frame opens with the link clock parked low
  sequence s_lead;
    !sclk [*2];
  endsequence
  a_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("link clock high outside frame");
  a_sclk_still_idle: assert property (cs_n ##1 cs_n |-> $stable(sclk)) else $error("link clock moved while idle");
  a_half_period_two: assert property ($changed(sclk) |=> $stable(sclk)) else $error("link half period short");
  a_frame_lead_low: assert property ($fell(cs_n) |-> s_lead) else $error("frame lead too short");
  a_frame_trail_low: assert property ($rose(cs_n) |-> !sclk && !sclk_q) else $error("frame ended with clock high");
  a_frame_whole_units: assert property ($rose(cs_n) |-> bits_q >= 16'h0002 && bits_q[0] == 1'b0) else $error("frame not whole units");
  a_dev_release_io: assert property ($rose(cs_n) |-> ##[0:4] d_oe == 4'h0) else $error("device still drives after frame");
  a_no_line_fight: assert property ((h_oe & d_oe) == 4'h0) else $error("both ends drive a line");
  a_io_pull_high: assert property ((h_oe | d_oe) == 4'h0 |-> io == 4'hF) else $error("released line not high");
endmodule

// >>> tb/flash_secreg_lock_reset_cmds_test.sv
// self-checking bench joining the host and device ends over the link
`timescale 1ns/1ps
module flash_secreg_lock_reset_cmds_test;
  import fsrl_pkg::*;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, cmd_valid = 1'b0, quad = 1'b0;
  logic sec_lock = 1'b0, write_protect_select = 1'b0, err_seen = 1'b0;
  logic [7:0] cmd_op = 8'h00, wr_data = 8'h00, rd_data;
  logic [31:0] cmd_adr = 32'h0000_0000;
  logic [2:0] cmd_alen = 3'h0, cmd_dummy = 3'h0;
  logic [8:0] cmd_nwr = 9'h000, blk_idx = 9'h000;
  logic [12:0] cmd_nrd = 13'h0000;
  logic ready, wr_take, rd_valid, err, blk_prot, write_in_progress_flag, write_enable_latch, adr4, rst_busy;
  logic [7:0] rdq[$]; // bytes received in last frame
  int fail_count = 0, checks_done = 0, seed = 51167, cyc = 0;
  fsrl_link_if fsrl_link_if_inst ();
  fsrl_host #(.DIV(2)) fsrl_host_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .lk(fsrl_link_if_inst), .cmd_valid_i(cmd_valid), .cmd_ready_o(ready), .cmd_op_i(cmd_op),
    .cmd_adr_i(cmd_adr), .cmd_alen_i(cmd_alen), .cmd_dummy_i(cmd_dummy), .cmd_nwr_i(cmd_nwr),
    .cmd_nrd_i(cmd_nrd), .cmd_quad_i(quad), .wr_data_i(wr_data), .wr_take_o(wr_take),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .err_o(err));
  fsrl_dev #(.LOCK_N(512), .PP_CYCLES(200), .RST_CYCLES(100)) fsrl_dev_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .lk(fsrl_link_if_inst), .quad_mode_i(quad),
    .sec_lock_i(sec_lock), .wps_i(write_protect_select), .blk_idx_i(blk_idx), .blk_prot_o(blk_prot),
    .wip_o(write_in_progress_flag), .wel_o(write_enable_latch), .adr4_o(adr4), .rst_busy_o(rst_busy));
  fsrl_link_monitor fsrl_link_monitor_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .sclk(fsrl_link_if_inst.sclk), .cs_n(fsrl_link_if_inst.cs_n), .h_oe(fsrl_link_if_inst.h_oe),
    .d_oe(fsrl_link_if_inst.d_oe), .io(fsrl_link_if_inst.io));
  // ************************************************************
  // clock, watchdog, compare and verdict
  // ************************************************************
  initial forever #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one request, gathers read bytes and refusal
  task automatic send(input logic [7:0] op, input logic [31:0] adr, input logic [2:0] alen,
                      input logic [2:0] dum, input logic [8:0] nwr, input logic [12:0] nrd);
    int n = 0, tail = 0;
    rdq = {};
    err_seen = 1'b0;
    @(negedge core_clk_i);
    {cmd_op, cmd_adr, cmd_alen, cmd_dummy, cmd_nwr, cmd_nrd} = {op, adr, alen, dum, nwr, nrd};
    cmd_valid = 1'b1;
    @(negedge core_clk_i);
    cmd_valid = 1'b0;
    while (tail < 8 && n < 3000) begin
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
      if (err === 1'b1) err_seen = 1'b1;
      n++;
      tail = (n >= 3 && ready === 1'b1) ? tail + 1 : 0;
      @(negedge core_clk_i);
    end
  endtask
  // opcode-only frame
  task automatic op1(input logic [7:0] op);
    send(op, 32'h0, 3'h0, 3'h0, 9'h000, 13'h0000);
  endtask
  initial begin
    logic [8:0] g;
    repeat (20) @(negedge core_clk_i);
    nrst_i = 1'b1;
    for (int k = 0; k < 2; k++) begin
      g = k ? 9'h0FF : {1'b0, 8'($random(seed))};
      blk_idx = g;
      send(OP_BLK_LOCK, {8'h00, g[7:0], 16'h1234}, 3'h3, 3'h0, 9'h000, 13'h0000);
      check(blk_prot, 1);
      write_protect_select = 1'b1;
      #1 check(blk_prot, 0);
      write_protect_select = 1'b0;
      send(OP_LOCK_READ, {8'h00, g[7:0], 16'h0000}, 3'h3, 3'h0, 9'h000, 13'h0001);
      check(rdq[0], 8'h01);
      send(OP_BLK_UNLOCK, {8'h00, g[7:0], 16'h00FF}, 3'h3, 3'h0, 9'h000, 13'h0000);
      check(blk_prot, 0);
    end
    op1(OP_GLB_LOCK);
    blk_idx = 9'($random(seed));
    #1 check(blk_prot, 1);
    op1(OP_GLB_UNLOCK);
    check(blk_prot, 0);
    op1(OP_ADR4_ON);
    check(adr4, 1);
    blk_idx = 9'h1A5;
    send(OP_BLK_LOCK, 32'h01A5_0000, 3'h4, 3'h0, 9'h000, 13'h0000);
    check(blk_prot, 1);
    op1(OP_ADR4_OFF);
    check(adr4, 0);
    $display("lock tests done");
    wr_data = 8'($random(seed)) & 8'h7F;
    op1(OP_WEN);
    op1(OP_WDIS);
    check(write_enable_latch, 0);
    send(OP_SEC_PROG, 32'h0000_0FFF, 3'h3, 3'h0, 9'h001, 13'h0000);
    check(err_seen, 1);
    op1(OP_WEN);
    check(write_enable_latch, 1);
    send(OP_SEC_PROG, 32'h0000_1FFF, 3'h3, 3'h0, 9'h001, 13'h0000);
    check(err_seen, 1);
    op1(OP_WEN);
    send(OP_SEC_PROG, 32'h0000_0FFF, 3'h3, 3'h0, 9'h001, 13'h0000);
    check({write_in_progress_flag, write_enable_latch}, 2'b10);
    repeat (220) @(negedge core_clk_i);
    check(write_in_progress_flag, 0);
    send(OP_SEC_READ, 32'h0000_0FFE, 3'h3, 3'h1, 9'h000, 13'h0003);
    check({rdq[0], rdq[1], rdq[2]}, {8'hFF, wr_data, 8'hFF});
    sec_lock = 1'b1;
    op1(OP_WEN);
    send(OP_SEC_PROG, 32'h0000_0010, 3'h3, 3'h0, 9'h001, 13'h0000);
    check(write_in_progress_flag, 0);
    sec_lock = 1'b0;
    $display("security register tests done");
    op1(OP_RST);
    check(err_seen, 1);
    op1(OP_ADR4_ON);
    op1(OP_WEN);
    send(OP_SEC_PROG, 32'h0000_0100, 3'h4, 3'h0, 9'h001, 13'h0000);
    op1(OP_RST_EN);
    op1(OP_RST);
    check({write_in_progress_flag, write_enable_latch, adr4, rst_busy}, 4'b0001);
    op1(OP_WEN);
    check(write_enable_latch, 0);
    repeat (120) @(negedge core_clk_i);
    quad = 1'b1;
    op1(OP_RST_EN);
    op1(OP_RST);
    check(rst_busy, 1);
    quad = 1'b0;
    repeat (120) @(negedge core_clk_i);
    send(OP_PARAM_READ, 32'h0, 3'h3, 3'h1, 9'h000, 13'h0004);
    for (int i = 0; i < 4; i++) check(rdq[i], PARAM_SIG[8*i +: 8]);
    $display("reset and parameter tests done");
    conclude();
  end
endmodule
